// File: logic/dcr_top.sv
// Deflection controller register bank, serial slave and operating-mode sequencer
// Summary of operation
// RULE1 - Host writes all fields sharing an address together; whole byte is overwritten.
// RULE2 - Protection trip clears low-power and ramp-up bits without any host write.
// RULE3 - Vertical moire is bits 2..0 of 03h, active only while moire-off clear.
// RULE4 - Horizontal moire is bits 4..0 of 05h, upper bits ignored, moire-off gated.
// RULE5 - Horizontal phase is full byte at 06h, signed offset about mid-scale.
// RULE6 - Below start-up level hold power-on reset and acknowledge nothing.
// RULE7 - Leaving power-on reset enters standby with start bit values, unlock high.
// RULE8 - Low-power cleared enables supply; only vertical stage on, unlock high.
// RULE9 - Below operating level, writes setting ramp-up bit are ignored.
// RULE10 - One byte per transfer; no auto-increment, extra bytes not acknowledged.
// RULE11 - Host waits the start delay after supply enable before setting ramp-up.
// RULE12 - Ramp-up ramps line drive then converter drive, enables both loops.
// RULE13 - In operation unlock output is low while loop A is locked.
// RULE14 - In operation register writes reach outputs immediately, no double buffer.
// RULE15 - Operation left only by clearing ramp-up; soft-down ramps converter then line. Code also leaves it on operating dip, protection trip or shutdown dip.
// RULE16 - Protection floats drives and unlock, blanks continuously, stops loops, keeps registers.
// RULE17 - Protection exits to standby, to new soft start, or on shutdown dip.
// RULE18 - Standby keeps only bus and protection; drivers float; registers lost.
// RULE19 - Dip below operating level runs soft-down then internal soft start.
// RULE20 - Dip below shutdown level kills all drivers and forces standby at once.
// RULE21 - Device answers only the fixed slave address with write bit.
// RULE22 - Low-power is bit 0 of 0Dh, ramp-up bit 1; ramp-up 0 grounds filter.
// RULE23 - Supply levels arrive as three synchronised comparator flags driving the modes.
`timescale 1ns/1ns
`default_nettype none
module dcr_top
   import dcr_pkg::*;
#(
   parameter int STEP_CYC = RAMP_STEP_CYC
)
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire dcr_supply_s i_supply,
   input wire logic i_protect_trip,
   input wire logic i_loop_a_locked,
   output logic o_line_drive_out,
   output logic o_line_drive_oe_n,
   output logic o_converter_drive_out,
   output logic o_converter_drive_oe_n,
   output logic o_line_unlock_out,
   output logic o_line_unlock_oe_n,
   output logic o_clamp_blank_out,
   output logic o_loop_a_en,
   output logic o_loop_b_en,
   output logic o_loop_b_filter_pin_gnd,
   output logic o_supply_en,
   output logic o_vert_out_en,
   output logic o_low_power_bit,
   output logic o_ramp_up_bit,
   output logic o_moire_off_switch,
   output dcr_geom_s o_geom,
   output logic [2:0] o_vert_moire_eff,
   output logic [4:0] o_horiz_moire_eff,
   output logic signed [7:0] o_horiz_phase_ofs,
   output dcr_mode_e o_mode
);
   // ----------------------------------------------------------------
   // State and input synchronisers
   // ----------------------------------------------------------------
   typedef struct packed {
      dcr_mode_e mode;
      logic dip_restart, low_power_bit, ramp_up_bit, moire_off_switch;
      dcr_geom_s geom;
      dcr_i2c_e bus;
      logic [7:0] shift;
      logic [3:0] bitcnt;
      logic [7:0] sub_addr;
      logic ack_drive, scl_q, sda_q;
      logic [15:0] step_cnt;
      logic step;
   } dcr_state_s;
   dcr_state_s st_r;
   dcr_state_s st_nxt;
   logic scl_s, sda_s, trip_s, locked_s;
   dcr_supply_s sup_s;
   logic line_full, line_zero, conv_full, conv_zero;
   logic drives_on, line_up, line_down, conv_up, conv_down;
   logic scl_rise, scl_fall, bus_start, bus_stop, ack_ok, wr_data;

   // Comparators and lock detector are analog, so they get two flops too
   dcr_sync #(.W(7)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_async({i_scl, i_sda, i_supply, i_protect_trip, i_loop_a_locked}),
      .o_sync({scl_s, sda_s, sup_s, trip_s, locked_s}) // RULE23
   );
   // Bus edges; start and stop count only with the clock high on both samples
   assign scl_rise = scl_s && !st_r.scl_q;
   assign scl_fall = !scl_s && st_r.scl_q;
   assign bus_start = scl_s && st_r.scl_q && st_r.sda_q && !sda_s;
   assign bus_stop = scl_s && st_r.scl_q && !st_r.sda_q && sda_s;
   // No acknowledge while in power-on reset or under a shutdown dip
   assign ack_ok = sup_s.por_ok && sup_s.above_shutdown && (st_r.mode != M_POR); // RULE6
   assign wr_data = scl_fall && (st_r.bitcnt == 4'h8) && !st_r.ack_drive
                    && (st_r.bus == I_DATA) && ack_ok;
   // Line ramps up before the converter; soft-down runs the other way round
   assign drives_on = (st_r.mode == M_SOFT_START) || (st_r.mode == M_OPERATE)
                      || (st_r.mode == M_SOFT_DOWN);
   assign line_up = (st_r.mode == M_SOFT_START); // RULE12
   assign conv_up = (st_r.mode == M_SOFT_START) && line_full; // RULE12
   assign conv_down = (st_r.mode == M_SOFT_DOWN); // RULE15
   assign line_down = (st_r.mode == M_SOFT_DOWN) && conv_zero; // RULE15
   dcr_duty_ramp u_line_ramp (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_step(st_r.step),
      .i_up(line_up),
      .i_down(line_down),
      .i_kill(!drives_on),
      .o_pwm(o_line_drive_out),
      .o_full(line_full),
      .o_zero(line_zero)
   );
   dcr_duty_ramp u_conv_ramp (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_step(st_r.step),
      .i_up(conv_up),
      .i_down(conv_down),
      .i_kill(!drives_on),
      .o_pwm(o_converter_drive_out),
      .o_full(conv_full),
      .o_zero(conv_zero)
   );

   // ----------------------------------------------------------------
   // Next-state logic: bus slave, register writes, mode sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.scl_q = scl_s;
      st_nxt.sda_q = sda_s;
      // Ramp step divider, one-cycle enable
      st_nxt.step = (st_r.step_cnt == 16'(STEP_CYC - 1));
      st_nxt.step_cnt = st_nxt.step ? 16'h0000 : st_r.step_cnt + 16'h0001;
      // Serial slave: bits shift on clock rise, bytes close on clock fall
      if (bus_start || bus_stop)
      begin
         st_nxt.bus = bus_start ? I_ADDR : I_IDLE;
         st_nxt.bitcnt = '0;
         st_nxt.ack_drive = 1'b0;
      end
      else if (st_r.bus != I_IDLE)
      begin
         if (scl_rise && (st_r.bitcnt < 4'h8))
         begin
            st_nxt.shift = {st_r.shift[6:0], sda_s};
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
         end
         else if (scl_fall && st_r.ack_drive)
         begin
            st_nxt.ack_drive = 1'b0;
            st_nxt.bitcnt = '0;
         end
         else if (scl_fall && (st_r.bitcnt == 4'h8))
         begin
            st_nxt.bitcnt = '0;
            case (st_r.bus)
               I_ADDR:
               begin
                  if ((st_r.shift == SLAVE_ADDR) && ack_ok) // RULE21
                  begin
                     st_nxt.ack_drive = 1'b1;
                     st_nxt.bus = I_SUB;
                  end
                  else
                     st_nxt.bus = I_IDLE; // RULE6
               end
               I_SUB:
               begin
                  st_nxt.sub_addr = st_r.shift;
                  st_nxt.ack_drive = ack_ok;
                  st_nxt.bus = ack_ok ? I_DATA : I_IDLE;
               end
               I_DATA:
               begin
                  st_nxt.ack_drive = ack_ok;
                  st_nxt.bus = ack_ok ? I_DONE : I_IDLE;
               end
               // Further bytes of the same transfer are left unanswered
               I_DONE: st_nxt.bus = I_IDLE; // RULE10
               default: st_nxt.bus = I_IDLE;
            endcase
         end
      end
      // Register write: the whole byte lands at once, shared fields included
      if (wr_data)
      begin
         case (st_r.sub_addr) // RULE14
            SUB_HSIZE: st_nxt.geom.horiz_size_adj = st_r.shift;
            SUB_SWITCH: st_nxt.moire_off_switch = st_r.shift[MOIRE_OFF_POS];
            SUB_VERT_POSITION_ADJ: st_nxt.geom.vert_position_adj = st_r.shift[7:1];
            SUB_VBAL_MOIRE:
            begin
               st_nxt.geom.vert_linearity_balance_adj = st_r.shift[6:3]; // RULE1
               st_nxt.geom.vert_moire_adj = st_r.shift[2:0]; // RULE3
            end
            SUB_PIN: st_nxt.geom.pincushion_adj = st_r.shift[5:0];
            SUB_HORIZ_MOIRE_ADJ: st_nxt.geom.horiz_moire_adj = st_r.shift[4:0]; // RULE4
            SUB_HPHASE: st_nxt.geom.horiz_phase_adj = st_r.shift; // RULE5
            SUB_VERT_S_CORRECTION_ADJ_EWBAL:
            begin
               st_nxt.geom.vert_s_correction_adj = st_r.shift[7:4];
               st_nxt.geom.ew_pin_balance_adj = st_r.shift[3:0];
            end
            SUB_VAMP: st_nxt.geom.vert_amplitude_adj = st_r.shift[7:1];
            SUB_CORNER: st_nxt.geom.corner_correction_adj = st_r.shift[4:0];
            SUB_FOCUS:
            begin
               st_nxt.geom.vert_focus_adj = st_r.shift[7:5];
               st_nxt.geom.horiz_focus_adj = st_r.shift[4:0];
            end
            SUB_TRAP_PARAL:
            begin
               st_nxt.geom.trapezium_adj = st_r.shift[7:4];
               st_nxt.geom.parallelogram_adj = st_r.shift[3:0];
            end
            SUB_POWER:
            begin
               st_nxt.low_power_bit = st_r.shift[LOW_POWER_POS]; // RULE22
               // Setting ramp-up is refused while the supply is under level
               if (sup_s.oper_ok || !st_r.shift[RAMP_UP_POS])
                  st_nxt.ramp_up_bit = st_r.shift[RAMP_UP_POS]; // RULE9
            end
            default: st_nxt.sub_addr = st_r.sub_addr;
         endcase
      end
      // Mode sequencer
      case (st_r.mode)
         M_POR: st_nxt.mode = sup_s.por_ok ? M_STANDBY : M_POR; // RULE7
         M_STANDBY: st_nxt.mode = st_nxt.low_power_bit ? M_STANDBY : M_SUPPLY_ON; // RULE8
         M_SUPPLY_ON:
         begin
            if (st_nxt.low_power_bit)
               st_nxt.mode = M_STANDBY;
            else if (st_nxt.ramp_up_bit)
               st_nxt.mode = M_SOFT_START; // RULE12
         end
         M_SOFT_START:
         begin
            if (!st_nxt.ramp_up_bit)
               st_nxt.mode = M_SOFT_DOWN;
            else if (line_full && conv_full)
               st_nxt.mode = M_OPERATE;
         end
         M_OPERATE:
         begin
            if (!st_nxt.ramp_up_bit)
               st_nxt.mode = M_SOFT_DOWN; // RULE15
            else if (!sup_s.oper_ok)
            begin
               st_nxt.mode = M_SOFT_DOWN; // RULE19
               st_nxt.dip_restart = 1'b1;
            end
         end
         M_SOFT_DOWN:
         begin
            if (line_zero && conv_zero)
            begin
               if (st_r.dip_restart && st_nxt.ramp_up_bit)
               begin
                  // Restart on our own once the supply is back up
                  if (sup_s.oper_ok)
                  begin
                     st_nxt.mode = M_SOFT_START; // RULE19
                     st_nxt.dip_restart = 1'b0;
                  end
               end
               else
               begin
                  st_nxt.dip_restart = 1'b0;
                  st_nxt.mode = st_nxt.low_power_bit ? M_STANDBY : M_SUPPLY_ON;
               end
            end
         end
         M_PROTECT:
         begin
            if (st_nxt.ramp_up_bit)
               st_nxt.mode = M_SOFT_START; // RULE17
            else if (st_nxt.low_power_bit)
               st_nxt.mode = M_STANDBY; // RULE17
         end
         default: st_nxt.mode = M_POR;
      endcase
      // Protection trip overrides the host and drops both power bits
      if (trip_s && drives_on)
      begin
         st_nxt.mode = M_PROTECT; // RULE16
         st_nxt.ramp_up_bit = 1'b0; // RULE2
         st_nxt.low_power_bit = 1'b0; // RULE2
         st_nxt.dip_restart = 1'b0;
      end
      // Shutdown dip, in any mode but power-on reset, ends in standby with drivers killed
      if (!sup_s.above_shutdown && (st_r.mode != M_POR))
      begin
         st_nxt.mode = M_STANDBY; // RULE20
         st_nxt.low_power_bit = LOW_POWER_START;
         st_nxt.ramp_up_bit = RAMP_UP_START;
         st_nxt.dip_restart = 1'b0;
      end
      // Power-on reset holds the mode, power bits and bus at start values
      if (!sup_s.por_ok)
      begin
         st_nxt.mode = M_POR; // RULE6
         st_nxt.low_power_bit = LOW_POWER_START;
         st_nxt.ramp_up_bit = RAMP_UP_START;
         st_nxt.bus = I_IDLE;
         st_nxt.ack_drive = 1'b0;
         st_nxt.dip_restart = 1'b0;
      end
      // Standby loses every register except the two power bits
      if (st_nxt.mode == M_STANDBY)
      begin
         st_nxt.geom = '0; // RULE18
         st_nxt.moire_off_switch = 1'b0;
      end
   end

   // First enum members are zero codes, so clearing lands in power-on reset and idle
   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_r <= '0;
         st_r.low_power_bit <= LOW_POWER_START; // RULE7
         st_r.ramp_up_bit <= RAMP_UP_START; // RULE7
         st_r.scl_q <= 1'b1;
         st_r.sda_q <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open-drain data line: only ever pulled low for acknowledge
   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = !st_r.ack_drive;
   // Drive stages float outside the ramp and run modes
   assign o_line_drive_oe_n = !drives_on; // RULE18
   assign o_converter_drive_oe_n = !drives_on; // RULE16
   // Unlock floats in protection, high until running, then shows loop A lock
   assign o_line_unlock_oe_n = (st_r.mode == M_PROTECT); // RULE16
   assign o_line_unlock_out = (st_r.mode == M_OPERATE) ? !locked_s : 1'b1; // RULE13
   assign o_clamp_blank_out = (st_r.mode == M_PROTECT); // RULE16
   assign o_loop_a_en = drives_on; // RULE12
   assign o_loop_b_en = drives_on;
   assign o_loop_b_filter_pin_gnd = !st_r.ramp_up_bit; // RULE22
   assign o_supply_en = (st_r.mode != M_POR) && !st_r.low_power_bit; // RULE8
   assign o_vert_out_en = o_supply_en;
   assign o_low_power_bit = st_r.low_power_bit;
   assign o_ramp_up_bit = st_r.ramp_up_bit;
   assign o_moire_off_switch = st_r.moire_off_switch;
   assign o_geom = st_r.geom;
   assign o_vert_moire_eff = st_r.moire_off_switch ? 3'h0 : st_r.geom.vert_moire_adj; // RULE3
   assign o_horiz_moire_eff = st_r.moire_off_switch ? 5'h00 : st_r.geom.horiz_moire_adj; // RULE4
   assign o_horiz_phase_ofs = $signed(st_r.geom.horiz_phase_adj ^ PHASE_MID); // RULE5
   assign o_mode = st_r.mode;
endmodule // dcr_top
`default_nettype wire

// File: common/dcr_pkg.sv
// Shared constants, enums and carriers for the deflection control register bank
package dcr_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int RAMP_STEP_NS = 10000;
   localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int DUTY_W = 8;

   // ----------------------------------------------------------------
   // Serial bus address, write direction included
   // ----------------------------------------------------------------
   localparam logic [7:0] SLAVE_ADDR = 8'h8C;

   // ----------------------------------------------------------------
   // Subaddresses
   // ----------------------------------------------------------------
   localparam logic [7:0] SUB_HSIZE = 8'h00;
   localparam logic [7:0] SUB_SWITCH = 8'h01;
   localparam logic [7:0] SUB_VERT_POSITION_ADJ = 8'h02;
   localparam logic [7:0] SUB_VBAL_MOIRE = 8'h03;
   localparam logic [7:0] SUB_PIN = 8'h04;
   localparam logic [7:0] SUB_HORIZ_MOIRE_ADJ = 8'h05;
   localparam logic [7:0] SUB_HPHASE = 8'h06;
   localparam logic [7:0] SUB_VERT_S_CORRECTION_ADJ_EWBAL = 8'h07;
   localparam logic [7:0] SUB_VAMP = 8'h08;
   localparam logic [7:0] SUB_CORNER = 8'h09;
   localparam logic [7:0] SUB_FOCUS = 8'h0A;
   localparam logic [7:0] SUB_TRAP_PARAL = 8'h0C;
   localparam logic [7:0] SUB_POWER = 8'h0D;

   // ----------------------------------------------------------------
   // Field positions and start values
   // ----------------------------------------------------------------
   localparam int MOIRE_OFF_POS = 5;
   localparam int LOW_POWER_POS = 0;
   localparam int RAMP_UP_POS = 1;
   localparam logic LOW_POWER_START = 1'b1;
   localparam logic RAMP_UP_START = 1'b0;
   localparam logic [7:0] PHASE_MID = 8'h80;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      M_POR, M_STANDBY, M_SUPPLY_ON, M_SOFT_START, M_OPERATE, M_SOFT_DOWN, M_PROTECT
   } dcr_mode_e;

   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_SUB, I_DATA, I_DONE} dcr_i2c_e;

   typedef struct packed {
      logic por_ok;
      logic oper_ok;
      logic above_shutdown;
   } dcr_supply_s;

   typedef struct packed {
      logic [7:0] horiz_size_adj;
      logic [6:0] vert_position_adj;
      logic [3:0] vert_linearity_balance_adj;
      logic [2:0] vert_moire_adj;
      logic [5:0] pincushion_adj;
      logic [4:0] horiz_moire_adj;
      logic [7:0] horiz_phase_adj;
      logic [3:0] vert_s_correction_adj;
      logic [3:0] ew_pin_balance_adj;
      logic [6:0] vert_amplitude_adj;
      logic [4:0] corner_correction_adj;
      logic [2:0] vert_focus_adj;
      logic [4:0] horiz_focus_adj;
      logic [3:0] trapezium_adj;
      logic [3:0] parallelogram_adj;
   } dcr_geom_s;

endpackage

// File: logic/dcr_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module dcr_sync
   import dcr_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } dcr_sync_s;

   dcr_sync_s st_r;
   dcr_sync_s st_nxt;

   // First stage feeds only the second stage
   always_comb
   begin
      st_nxt.meta = i_async;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_sync = st_r.sync;
endmodule // dcr_sync
`default_nettype wire

// File: logic/dcr_duty_ramp.sv
// Duty-cycle ramp with PWM output for one drive stage
`timescale 1ns/1ns
`default_nettype none
module dcr_duty_ramp
   import dcr_pkg::*;
#(
   parameter int W = DUTY_W
)
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_step,
   input wire logic i_up,
   input wire logic i_down,
   input wire logic i_kill,
   output logic o_pwm,
   output logic o_full,
   output logic o_zero
);
   typedef struct packed {
      logic [W-1:0] duty;
      logic [W-1:0] phase;
      logic pwm;
   } dcr_ramp_s;

   dcr_ramp_s st_r;
   dcr_ramp_s st_nxt;

   // Kill wins so a shutdown dip stops the stage in one cycle
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.phase = st_r.phase + 1'b1;
      if (i_kill)
         st_nxt.duty = '0;
      else if (i_up && i_step && !o_full)
         st_nxt.duty = st_r.duty + 1'b1;
      else if (i_down && i_step && !o_zero)
         st_nxt.duty = st_r.duty - 1'b1;
      st_nxt.pwm = !i_kill && (st_r.phase < st_r.duty);
   end

   always_ff @(posedge i_clk_sys or posedge i_reset)
   begin
      if (i_reset)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_pwm = st_r.pwm;
   assign o_full = &st_r.duty;
   assign o_zero = ~|st_r.duty;
endmodule // dcr_duty_ramp
`default_nettype wire

// File: testbench/dcr_assertions.sv
// Checker for mode-driven outputs of the register bank
`timescale 1ns/1ns
`default_nettype none
module dcr_assertions
   import dcr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire dcr_supply_s i_supply,
   input wire dcr_mode_e o_mode,
   input wire logic o_line_drive_oe_n,
   input wire logic o_clamp_blank_out,
   input wire logic o_line_unlock_out,
   input wire logic o_ramp_up_bit,
   input wire logic o_loop_b_filter_pin_gnd,
   input wire logic o_moire_off_switch,
   input wire dcr_geom_s o_geom,
   input wire logic [2:0] o_vert_moire_eff,
   input wire logic [4:0] o_horiz_moire_eff,
   input wire logic signed [7:0] o_horiz_phase_ofs
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // ---
   // Properties; stable guards skip the one-cycle output lag
   // ---
   sequence s_dip;
      !i_supply.above_shutdown [*3] ##0 o_mode != M_POR;
   endsequence
   property p_dip;
      s_dip |-> ##[0:2] o_mode == M_STANDBY;
   endproperty
   property p_prot;
      $stable(o_mode) && o_mode == M_PROTECT |-> o_line_drive_oe_n && o_clamp_blank_out;
   endproperty
   property p_sby;
      $stable(o_mode) && o_mode == M_STANDBY |-> o_line_drive_oe_n && !o_clamp_blank_out;
   endproperty
   property p_unl;
      $stable(o_mode) && o_mode inside {M_STANDBY, M_SUPPLY_ON} |-> o_line_unlock_out;
   endproperty
   property p_filt;
      $stable(o_ramp_up_bit) |-> o_loop_b_filter_pin_gnd == !o_ramp_up_bit;
   endproperty
   property p_vm;
      $stable(o_geom) && $stable(o_moire_off_switch)
         |-> o_vert_moire_eff == (o_moire_off_switch ? 3'h0 : o_geom.vert_moire_adj);
   endproperty
   property p_hm;
      $stable(o_geom) && $stable(o_moire_off_switch)
         |-> o_horiz_moire_eff == (o_moire_off_switch ? 5'h00 : o_geom.horiz_moire_adj);
   endproperty
   property p_ph;
      $stable(o_geom) |-> o_horiz_phase_ofs == $signed(o_geom.horiz_phase_adj - 8'h80);
   endproperty
   a_dip: assert property (p_dip) else $error("no standby after dip");
   a_prot: assert property (p_prot) else $error("protect outputs");
   a_sby: assert property (p_sby) else $error("standby drives");
   a_unl: assert property (p_unl) else $error("unlock not high");
   a_filt: assert property (p_filt) else $error("filter ground");
   a_vm: assert property (p_vm) else $error("vert moire");
   a_hm: assert property (p_hm) else $error("horiz moire");
   a_ph: assert property (p_ph) else $error("phase offset");
endmodule // dcr_assertions
bind dcr_top dcr_assertions u_chk (.i_clk_sys, .i_reset, .i_supply, .o_mode,
   .o_line_drive_oe_n, .o_clamp_blank_out, .o_line_unlock_out, .o_ramp_up_bit,
   .o_loop_b_filter_pin_gnd, .o_moire_off_switch, .o_geom, .o_vert_moire_eff,
   .o_horiz_moire_eff, .o_horiz_phase_ofs);
`default_nettype wire

// File: testbench/dcr_host.sv
// Host model: serial bus master, 80 ns link clock, open drain
`timescale 1ns/1ns
`default_nettype none
module dcr_host
   import dcr_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda
);
   initial o_scl = 1'b1;
   initial o_sda = 1'b1;
   // Half link period is four system clocks
   task automatic hp;
      repeat (4) @(posedge i_clk_sys);
   endtask
   // Data moves only while the link clock is low
   task automatic bit_io(input logic b, output logic r);
      o_scl <= 1'b0;
      o_sda <= b;
      hp;
      o_scl <= 1'b1;
      hp;
      r = i_sda;
   endtask
   // Start, n whole bytes with acks, stop; ak bit set per acked byte
   task automatic wr(input logic [7:0] a, s, d, input int n, output logic [3:0] ak);
      logic r;
      logic [7:0] q [4];
      q = '{a, s, d, ~d};
      ak = 4'h0;
      o_sda <= 1'b0;
      hp;
      for (int k = 0; k < n; k++)
      begin
         for (int j = 7; j >= 0; j--)
            bit_io(q[k][j], r);
         bit_io(1'b1, r);
         ak[3-k] = !r;
      end
      o_scl <= 1'b0;
      o_sda <= 1'b0;
      hp;
      o_scl <= 1'b1;
      hp;
      o_sda <= 1'b1;
      hp;
   endtask
endmodule // dcr_host
`default_nettype wire

// File: testbench/dcr_top_test.sv
// Self-checking bench for the deflection register bank
`timescale 1ns/1ns
`default_nettype none
module dcr_top_test
   import dcr_pkg::*;
();
   logic i_clk_sys = 1'b0, i_reset = 1'b1, i_protect_trip = 1'b0, i_loop_a_locked = 1'b1;
   logic o_sda_out, o_sda_oe_n, o_line_drive_oe_n, o_line_unlock_out, o_clamp_blank_out;
   logic o_loop_a_en, o_supply_en, o_low_power_bit, o_ramp_up_bit, o_moire_off_switch;
   logic i_scl, h_sda;
   logic [2:0] o_vert_moire_eff;
   logic [4:0] o_horiz_moire_eff;
   logic signed [7:0] o_horiz_phase_ofs;
   logic [3:0] ak;
   dcr_geom_s o_geom;
   dcr_mode_e o_mode;
   dcr_supply_s i_supply = 3'h7;
   int n_mismatch = 0, checks = 0;
   // Pull-up wire: low when either party pulls
   wire logic i_sda = h_sda & (o_sda_oe_n | o_sda_out);
   dcr_top #(.STEP_CYC(2)) dut (.i_clk_sys, .i_reset, .i_scl, .i_sda, .o_sda_out, .o_sda_oe_n,
      .i_supply, .i_protect_trip, .i_loop_a_locked, .o_line_drive_out(), .o_line_drive_oe_n,
      .o_converter_drive_out(), .o_converter_drive_oe_n(), .o_line_unlock_out,
      .o_line_unlock_oe_n(), .o_clamp_blank_out, .o_loop_a_en, .o_loop_b_en(),
      .o_loop_b_filter_pin_gnd(), .o_supply_en, .o_vert_out_en(), .o_low_power_bit,
      .o_ramp_up_bit, .o_moire_off_switch, .o_geom, .o_vert_moire_eff, .o_horiz_moire_eff,
      .o_horiz_phase_ofs, .o_mode);
   dcr_host host (.i_clk_sys, .i_sda, .o_scl(i_scl), .o_sda(h_sda));
   initial forever #5 i_clk_sys = ~i_clk_sys;
   // ---
   // Shared tasks
   // ---
   task automatic chk(input string nm, input logic [7:0] s, e);
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Bounded wait for a mode; running out ends the run
   task automatic wt(input dcr_mode_e m);
      int k;
      for (k = 0; k < 3000 && o_mode !== m; k++)
         @(posedge i_clk_sys);
      chk("mode", o_mode, m);
      if (k == 3000)
         wrap_up;
   endtask
   task automatic w(input logic [7:0] s, d);
      host.wr(SLAVE_ADDR, s, d, 3, ak);
      chk("ack", ak, 4'hE);
   endtask
   initial
   begin
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      wt(M_STANDBY);
      chk("lp", o_low_power_bit, LOW_POWER_START);
      chk("ru", o_ramp_up_bit, RAMP_UP_START);
      host.wr(8'h8E, SUB_POWER, 8'h00, 3, ak);
      chk("bad addr", ak, 4'h0);
      w(SUB_POWER, 8'h00);
      wt(M_SUPPLY_ON);
      chk("sup", o_supply_en, 1'b1);
      chk("drv", o_line_drive_oe_n, 1'b1);
      $display("test standby done");
      i_supply.oper_ok <= 1'b0;
      w(SUB_POWER, 8'h02);
      chk("ru low", o_ramp_up_bit, 1'b0);
      i_supply.oper_ok <= 1'b1;
      w(SUB_VBAL_MOIRE, 8'h55);
      chk("vlb", o_geom.vert_linearity_balance_adj, 8'h0A);
      chk("vm", o_vert_moire_eff, 8'h05);
      w(SUB_HORIZ_MOIRE_ADJ, 8'hFF);
      chk("hm", o_horiz_moire_eff, 8'h1F);
      w(SUB_SWITCH, 8'h20);
      chk("hm off", o_horiz_moire_eff, 8'h00);
      host.wr(SLAVE_ADDR, SUB_HPHASE, 8'h40, 4, ak);
      chk("ack x", ak, 4'hE);
      chk("ofs", o_horiz_phase_ofs, 8'hC0);
      $display("test registers done");
      repeat (100) @(posedge i_clk_sys);
      w(SUB_POWER, 8'h02);
      wt(M_OPERATE);
      chk("loop", o_loop_a_en, 1'b1);
      chk("unl", o_line_unlock_out, 1'b0);
      w(SUB_HPHASE, 8'hFF);
      chk("ofs op", o_horiz_phase_ofs, 8'h7F);
      i_supply.oper_ok <= 1'b0;
      wt(M_SOFT_DOWN);
      i_supply.oper_ok <= 1'b1;
      wt(M_SOFT_START);
      wt(M_OPERATE);
      $display("test operate done");
      i_protect_trip <= 1'b1;
      wt(M_PROTECT);
      i_protect_trip <= 1'b0;
      chk("blank", o_clamp_blank_out, 1'b1);
      chk("ru clr", o_ramp_up_bit, 1'b0);
      chk("keep", o_geom.horiz_phase_adj, 8'hFF);
      w(SUB_POWER, 8'h03);
      wt(M_OPERATE);
      w(SUB_POWER, 8'h01);
      wt(M_SOFT_DOWN);
      wt(M_STANDBY);
      chk("lost", o_geom.horiz_phase_adj, 8'h00);
      $display("test protect done");
      w(SUB_POWER, 8'h00);
      wt(M_SUPPLY_ON);
      i_supply.above_shutdown <= 1'b0;
      wt(M_STANDBY);
      chk("lp dip", o_low_power_bit, 1'b1);
      i_supply <= 3'h3;
      wt(M_POR);
      host.wr(SLAVE_ADDR, SUB_POWER, 8'h00, 3, ak);
      chk("por ack", ak, 4'h0);
      $display("test supply done");
      wrap_up;
   end
endmodule // dcr_top_test
`default_nettype wire
